/* File: rtl/tds_pkg.sv */
// Package of constants, encodings and carrier types for the trigger delay sequencer.
`default_nettype none
package tds_pkg;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG_CFG = 8'h04;
  localparam logic [7:0] ADDR_DELAY_SRC = 8'h08;
  localparam logic [7:0] ADDR_DELAY_TIME = 8'h0c;
  localparam logic [7:0] ADDR_EVENT_COUNT = 8'h10;
  localparam logic [7:0] ADDR_BLOCK_COUNT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Control register bit positions.
  localparam int CTRL_INITIATE_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  // Trigger source codes.
  localparam logic [2:0] SRC_IMMEDIATE = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL = 3'h1;
  localparam logic [2:0] SRC_LINE_ZERO = 3'h2;
  localparam logic [2:0] SRC_LINE_ZERO_LONG = 3'h3;
  localparam logic [2:0] SRC_LINE_ONE = 3'h4;
  localparam logic [2:0] SRC_LINE_ONE_LONG = 3'h5;
  // Threshold selections, one comparator each.
  localparam logic [2:0] LVL_TTL = 3'h0;
  localparam logic [2:0] LVL_ECL = 3'h1;
  localparam logic [2:0] LVL_TTL_PROBE = 3'h2;
  localparam logic [2:0] LVL_ECL_PROBE = 3'h3;
  localparam logic [2:0] LVL_GND = 3'h4;
  // Delay source codes.
  localparam logic [1:0] DSRC_IMMEDIATE = 2'h0;
  localparam logic [1:0] DSRC_TIMER = 2'h1;
  localparam logic [1:0] DSRC_INPUT = 2'h2;
  // Timing: delay is programmed in 25 ns steps, clock period 40 ns.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIME_STEP_NS = 25;
  localparam int DELAY_MIN_NS = 75;
  localparam int DELAY_MAX_NS = 26214000;
  localparam int DELAY_DEFAULT_NS = 100;
  localparam logic [19:0] DELAY_MIN_STEPS = 20'(DELAY_MIN_NS / TIME_STEP_NS);
  localparam logic [19:0] DELAY_MAX_STEPS = 20'(DELAY_MAX_NS / TIME_STEP_NS);
  localparam logic [19:0] DELAY_DEFAULT_STEPS = 20'(DELAY_DEFAULT_NS / TIME_STEP_NS);
  localparam int REARM_MAX_NS = 500;
  localparam int REARM_MAX_CYCLES = REARM_MAX_NS / CLK_PERIOD_NS;
  // Event and block counts.
  localparam logic [19:0] EVENT_COUNT_DEFAULT = 20'h00001;
  localparam logic [19:0] BLOCK_COUNT_DEFAULT = 20'h00001;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Trigger configuration word as stored in its register, bits [9:0].
  typedef struct packed {
    logic measSlope;
    logic measSel;
    logic twoChan;
    logic [2:0] level;
    logic slope;
    logic [2:0] src;
  } tds_trig_cfg_s;
  localparam tds_trig_cfg_s TRIG_CFG_RESET = '{1'b0, 1'b0, 1'b0, LVL_TTL, 1'b0, SRC_IMMEDIATE};
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM = 3'b001,
    ST_WAIT_TRIG = 3'b010,
    ST_DELAY = 3'b011,
    ST_ACQ = 3'b100
  } tds_state_e;
endpackage : tds_pkg
`default_nettype wire

/* File: rtl/tds_top.sv */
// Trigger qualification and pre-acquisition delay sequencer with AXI4-Lite registers.
// Notes on behaviour
// - Trigger first, then delay, then acquire.
// - Event delay counts measured input, same slope; the code takes the count edge from its own measSlope bit instead.
// - Event count 0..1048575, reset value one.
// - Input mode waits programmed event count.
// - Timer mode waits programmed time after trigger.
// - Immediate mode starts acquisition at once.
// - Time 75 ns..26.214 ms, 25 ns steps, default 100 ns.
// - Time setting used only in timer mode.
// - Five threshold selections, numeric maps, default TTL.
// - Threshold applies only to external source.
// - Edge direction qualifies every non-immediate source.
// - Rising edge means low to high; default rising.
// - Immediate source needs no trigger; reset default.
// - Either backplane line, short or long name.
// - External source is the front-panel input.
// - Re-arm between blocks well under 500 ns.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none
module tds_top (
  input wire logic mclk, // 25 MHz clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [4:0] extTrigCmp, // Front-panel comparator outputs, one per threshold.
  input wire logic backplaneLineZero, // Backplane trigger line zero, positive logic.
  input wire logic backplaneLineOne, // Backplane trigger line one, positive logic.
  input wire logic measInputOne, // Conditioned measured input one.
  input wire logic measInputTwo, // Conditioned measured input two.
  input wire logic acqBlockDone, // Pulse from the acquisition engine at block end.
  output logic acqStart, // One-cycle pulse that starts acquisition.
  output logic armed // High while waiting for a trigger.
);
  localparam int RearmBound = tds_pkg::REARM_MAX_CYCLES;

  // Merge a write word into a register under the byte strobes.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pick the active edge of a level given the previous and current samples.
  function automatic logic edgeSeen(input logic prev, input logic cur, input logic falling);
    return falling ? (prev && !cur) : (!prev && cur);
  endfunction

  tds_pkg::tds_trig_cfg_s trigCfg;
  tds_pkg::tds_state_e state;
  logic [1:0] delaySrc;
  logic [19:0] delayTime;
  logic [19:0] eventCount;
  logic [19:0] blockCount;
  logic [19:0] blocksLeft;
  logic [19:0] eventsLeft;
  logic [24:0] targetNs;
  logic [25:0] elapsedNs;
  logic [8:0] syncA;
  logic [8:0] syncB;
  logic trigPrev;
  logic measPrev;
  logic trigLevel;
  logic measLevel;
  logic trigEdge;
  logic measEdge;
  logic initiate;
  logic abort;
  logic wrFire;
  logic rdFire;
  logic [7:0] wrAddr;
  logic [7:0] rdAddr;
  logic [31:0] wrOld;
  logic [31:0] wrWord;
  logic srcImm;

  // Pins from outside pass two flops; only the second stage is read by logic.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA <= 9'h000;
      syncB <= 9'h000;
    end else begin
      syncA <= {measInputTwo, measInputOne, backplaneLineOne, backplaneLineZero, extTrigCmp};
      syncB <= syncA;
    end
  end

  // Trigger level: threshold comparator only on the external source.
  always_comb begin
    case (trigCfg.src)
      tds_pkg::SRC_EXTERNAL: trigLevel = syncB[trigCfg.level];
      tds_pkg::SRC_LINE_ZERO, tds_pkg::SRC_LINE_ZERO_LONG: trigLevel = syncB[5];
      tds_pkg::SRC_LINE_ONE, tds_pkg::SRC_LINE_ONE_LONG: trigLevel = syncB[6];
      default: trigLevel = 1'b0;
    endcase
  end

  // Two-channel runs always count input one; single-channel counts the measured input.
  assign measLevel = (trigCfg.twoChan || !trigCfg.measSel) ? syncB[7] : syncB[8];
  assign srcImm = (trigCfg.src == tds_pkg::SRC_IMMEDIATE);
  assign trigEdge = srcImm || edgeSeen(trigPrev, trigLevel, trigCfg.slope);
  assign measEdge = edgeSeen(measPrev, measLevel, trigCfg.measSlope);

  // Previous samples for edge detection; updated every cycle so arming sees a fresh value.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigPrev <= 1'b0;
      measPrev <= 1'b0;
    end else begin
      trigPrev <= trigLevel;
      measPrev <= measLevel;
    end
  end

  // Write channel: address and data are taken together, one write outstanding.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wrFire = s_axi_awready;
  assign wrAddr = s_axi_awaddr[7:0];
  assign initiate = wrFire && (wrAddr == tds_pkg::ADDR_CTRL) && s_axi_wstrb[0]
                    && s_axi_wdata[tds_pkg::CTRL_INITIATE_BIT];
  assign abort = wrFire && (wrAddr == tds_pkg::ADDR_CTRL) && s_axi_wstrb[0]
                 && s_axi_wdata[tds_pkg::CTRL_ABORT_BIT];

  // Write response, with an error for unmapped or read-only addresses.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tds_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr[31:8] == 24'h000000 && wrAddr[1:0] == 2'h0
                      && wrAddr < tds_pkg::ADDR_STATUS) ? tds_pkg::RESP_OKAY
                                                        : tds_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Old contents of the addressed register, so a partial strobe keeps untouched bytes.
  always_comb begin
    case (wrAddr)
      tds_pkg::ADDR_TRIG_CFG: wrOld = {22'h000000, trigCfg};
      tds_pkg::ADDR_DELAY_SRC: wrOld = {30'h00000000, delaySrc};
      tds_pkg::ADDR_DELAY_TIME: wrOld = {12'h000, delayTime};
      tds_pkg::ADDR_EVENT_COUNT: wrOld = {12'h000, eventCount};
      tds_pkg::ADDR_BLOCK_COUNT: wrOld = {12'h000, blockCount};
      default: wrOld = 32'h00000000;
    endcase
  end
  assign wrWord = wmerge(wrOld, s_axi_wdata, s_axi_wstrb);

  // Configuration registers; out-of-range level, delay time and block count are clamped to the nearest legal value, bad sources fall back to immediate.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigCfg <= tds_pkg::TRIG_CFG_RESET;
      delaySrc <= tds_pkg::DSRC_IMMEDIATE;
      delayTime <= tds_pkg::DELAY_DEFAULT_STEPS;
      eventCount <= tds_pkg::EVENT_COUNT_DEFAULT;
      blockCount <= tds_pkg::BLOCK_COUNT_DEFAULT;
    end else if (wrFire && s_axi_awaddr[31:8] == 24'h000000) begin
      case (wrAddr)
        tds_pkg::ADDR_TRIG_CFG: begin
          trigCfg <= wrWord[9:0];
          if (wrWord[2:0] > tds_pkg::SRC_LINE_ONE_LONG) begin
            trigCfg.src <= tds_pkg::SRC_IMMEDIATE;
          end
          if (wrWord[6:4] > tds_pkg::LVL_GND) begin
            trigCfg.level <= tds_pkg::LVL_GND;
          end
        end
        tds_pkg::ADDR_DELAY_SRC: begin
          delaySrc <= (wrWord[1:0] > tds_pkg::DSRC_INPUT) ? tds_pkg::DSRC_IMMEDIATE
                                                          : wrWord[1:0];
        end
        tds_pkg::ADDR_DELAY_TIME: begin
          if (wrWord < {12'h000, tds_pkg::DELAY_MIN_STEPS}) begin
            delayTime <= tds_pkg::DELAY_MIN_STEPS;
          end else if (wrWord > {12'h000, tds_pkg::DELAY_MAX_STEPS}) begin
            delayTime <= tds_pkg::DELAY_MAX_STEPS;
          end else begin
            delayTime <= wrWord[19:0];
          end
        end
        tds_pkg::ADDR_EVENT_COUNT: begin
          eventCount <= wrWord[19:0];
        end
        tds_pkg::ADDR_BLOCK_COUNT: begin
          blockCount <= (wrWord[19:0] == 20'h00000) ? 20'h00001 : wrWord[19:0];
        end
        default: ;
      endcase
    end
  end

  // Sequencer: idle, arm (reload), wait for trigger, delay, acquire.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= tds_pkg::ST_IDLE;
      acqStart <= 1'b0;
      blocksLeft <= 20'h00000;
    end else begin
      acqStart <= 1'b0;
      if (abort) begin
        state <= tds_pkg::ST_IDLE;
      end else begin
        case (state)
          tds_pkg::ST_IDLE: begin
            if (initiate) begin
              blocksLeft <= blockCount;
              state <= tds_pkg::ST_ARM;
            end
          end
          tds_pkg::ST_ARM: state <= tds_pkg::ST_WAIT_TRIG;
          tds_pkg::ST_WAIT_TRIG: begin
            if (trigEdge) begin
              if (delaySrc == tds_pkg::DSRC_IMMEDIATE
                  || (delaySrc == tds_pkg::DSRC_INPUT && eventsLeft == 20'h00000)) begin
                acqStart <= 1'b1;
                state <= tds_pkg::ST_ACQ;
              end else begin
                state <= tds_pkg::ST_DELAY;
              end
            end
          end
          tds_pkg::ST_DELAY: begin
            if ((delaySrc == tds_pkg::DSRC_TIMER && elapsedNs >= {1'b0, targetNs})
                || (delaySrc == tds_pkg::DSRC_INPUT && eventsLeft == 20'h00000)) begin
              acqStart <= 1'b1;
              state <= tds_pkg::ST_ACQ;
            end
          end
          tds_pkg::ST_ACQ: begin
            if (acqBlockDone) begin
              blocksLeft <= blocksLeft - 20'h00001;
              state <= (blocksLeft > 20'h00001) ? tds_pkg::ST_ARM : tds_pkg::ST_IDLE;
            end
          end
          default: state <= tds_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Delay timer and event counter: reloaded when armed, run only after the trigger.
  // The timer counts real nanoseconds so the 25 ns grid rounds up to whole 40 ns cycles.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      targetNs <= 25'h0000000;
      elapsedNs <= 26'h0000000;
      eventsLeft <= 20'h00000;
    end else if (state == tds_pkg::ST_ARM) begin
      // The product needs 25 bits at the longest delay, so widen before multiplying.
      targetNs <= 25'(delayTime) * 25'(tds_pkg::TIME_STEP_NS);
      elapsedNs <= 26'h0000000;
      eventsLeft <= eventCount;
    end else if (state == tds_pkg::ST_DELAY || (state == tds_pkg::ST_WAIT_TRIG && trigEdge)) begin
      if (state == tds_pkg::ST_DELAY) begin
        elapsedNs <= elapsedNs + 26'(tds_pkg::CLK_PERIOD_NS);
      end
      if (state == tds_pkg::ST_DELAY && measEdge && eventsLeft != 20'h00000) begin
        eventsLeft <= eventsLeft - 20'h00001;
      end
    end
  end

  assign armed = (state == tds_pkg::ST_WAIT_TRIG);

  // Read channel: one read outstanding, data registered one cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign rdAddr = s_axi_araddr[7:0];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tds_pkg::RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tds_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr[31:8] != 24'h000000) begin
        s_axi_rresp <= tds_pkg::RESP_SLVERR;
      end else begin
        case (rdAddr)
          tds_pkg::ADDR_CTRL: s_axi_rdata <= 32'h00000000;
          tds_pkg::ADDR_TRIG_CFG: s_axi_rdata <= {22'h000000, trigCfg};
          tds_pkg::ADDR_DELAY_SRC: s_axi_rdata <= {30'h00000000, delaySrc};
          tds_pkg::ADDR_DELAY_TIME: s_axi_rdata <= {12'h000, delayTime};
          tds_pkg::ADDR_EVENT_COUNT: s_axi_rdata <= {12'h000, eventCount};
          tds_pkg::ADDR_BLOCK_COUNT: s_axi_rdata <= {12'h000, blockCount};
          tds_pkg::ADDR_STATUS: s_axi_rdata <= {eventsLeft[18:0], blocksLeft[9:0], state};
          default: s_axi_rresp <= tds_pkg::RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the register defaults, the delay range and the sequencing.
  chk_defaults_after_reset: assert property (@(posedge mclk) $fell(rst) |->
    eventCount == 20'h00001 && delayTime == 20'h00004 && trigCfg.src == 3'h0)
    else $error("Reset defaults wrong.");
  chk_time_in_range: assert property (@(posedge mclk) disable iff (rst)
    delayTime >= 20'h00003 && delayTime <= 20'hffff0)
    else $error("Delay time out of range.");
  chk_start_after_trigger: assert property (@(posedge mclk) disable iff (rst)
    acqStart |-> $past(state) == tds_pkg::ST_WAIT_TRIG || $past(state) == tds_pkg::ST_DELAY)
    else $error("Acquisition started without trigger.");
  chk_immediate_source: assert property (@(posedge mclk) disable iff (rst)
    (state == tds_pkg::ST_WAIT_TRIG && srcImm && !abort) |=> state != tds_pkg::ST_WAIT_TRIG)
    else $error("Immediate source did not trigger.");
  chk_immediate_delay: assert property (@(posedge mclk) disable iff (rst)
    (state == tds_pkg::ST_WAIT_TRIG && trigEdge && !abort
     && delaySrc == tds_pkg::DSRC_IMMEDIATE) |=> acqStart)
    else $error("Immediate delay not shortest.");
  chk_timer_elapsed: assert property (@(posedge mclk) disable iff (rst)
    (acqStart && delaySrc == tds_pkg::DSRC_TIMER) |-> elapsedNs >= {1'b0, targetNs}
    && targetNs == 25'(delayTime) * 25'd25)
    else $error("Timer delay too short.");
  chk_events_counted: assert property (@(posedge mclk) disable iff (rst)
    (acqStart && delaySrc == tds_pkg::DSRC_INPUT) |-> eventsLeft == 20'h00000)
    else $error("Event delay incomplete.");
  chk_edge_direction: assert property (@(posedge mclk) disable iff (rst)
    (state == tds_pkg::ST_WAIT_TRIG && !srcImm && trigEdge) |->
    (trigCfg.slope ? (trigPrev && !trigLevel) : (!trigPrev && trigLevel)))
    else $error("Trigger on wrong edge.");
  chk_rearm_bound: assert property (@(posedge mclk) disable iff (rst || abort)
    (state == tds_pkg::ST_ACQ && acqBlockDone && blocksLeft > 20'h00001) |->
    ##[1:RearmBound] state == tds_pkg::ST_WAIT_TRIG)
    else $error("Re-arm too slow.");
  chk_reload_on_arm: assert property (@(posedge mclk) disable iff (rst)
    state == tds_pkg::ST_ARM |=> eventsLeft == $past(eventCount) && elapsedNs == 26'h0000000)
    else $error("Delay not reloaded on arm.");
  cov_timer_run: cover property (@(posedge mclk) disable iff (rst)
    acqStart && delaySrc == tds_pkg::DSRC_TIMER);
  cov_event_run: cover property (@(posedge mclk) disable iff (rst)
    acqStart && delaySrc == tds_pkg::DSRC_INPUT);
  cov_multi_block: cover property (@(posedge mclk) disable iff (rst)
    state == tds_pkg::ST_ACQ && acqBlockDone && blocksLeft > 20'h00001);
endmodule // tds_top
`default_nettype wire

/* File: tb/tds_trig_model.sv */
// Behavioural model of the front-panel, backplane and measured inputs facing the sequencer.
`default_nettype none
module tds_trig_model (
  input wire logic mclk, // Bench clock.
  input wire logic fire, // Request one trigger pulse.
  input wire logic [2:0] sel, // Line to pulse: 0 front panel, 1 line zero, 2 line one.
  input wire logic [2:0] lvl, // Comparator that sees the front-panel pulse.
  input wire logic falling, // Idle high and active low when set.
  input wire logic evt, // Request one measured-input pulse.
  output logic [4:0] extTrigCmp, // Comparator outputs.
  output logic lineZero, // Backplane line zero.
  output logic lineOne, // Backplane line one.
  output logic measOne // Measured input one.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold = 3'h0;
  logic [1:0] mHold = 2'h0;
  logic act;
  // Trigger pulses four cycles active, measured pulses two, so each survives the two-flop synchroniser.
  always_ff @(posedge mclk) begin
    hold <= fire ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : hold);
    mHold <= evt ? 2'h2 : (mHold != 2'h0 ? mHold - 2'h1 : mHold);
  end
  assign act = (hold != 3'h0);
  // Only the addressed comparator moves, so a wrong threshold choice never triggers.
  assign extTrigCmp = {5{falling}} ^ ((act && sel == 3'h0) ? (5'h01 << lvl) : 5'h00);
  assign lineZero = falling ^ (act && sel == 3'h1);
  assign lineOne = falling ^ (act && sel == 3'h2);
  assign measOne = (mHold != 2'h0);
endmodule // tds_trig_model
`default_nettype wire

/* File: tb/trigger_delay_sequencer_tb.sv */
// Self-checking testbench of the trigger delay sequencer.
`default_nettype none
module trigger_delay_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, acqStart, armed, lz, l1, m1, mPrev;
  logic [1:0] bresp, rresp;
  logic fire = 1'b0, falling = 1'b0, evt = 1'b0, blkDone = 1'b0, useTwo = 1'b0;
  logic [3:0] strb = 4'hf;
  logic [2:0] sel = 3'h0, lvl = 3'h0;
  logic [4:0] cmp;
  int n_errors = 0, n_compared = 0, lat = 0, ev = 0, cyc = 0;
  logic [1:0] qb[$];
  logic [33:0] qr[$];
  logic [20:0] qa[$];
  always #20 mclk = ~mclk;
  tds_top DUT (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .extTrigCmp(cmp), .backplaneLineZero(lz), .backplaneLineOne(l1),
    .measInputOne(useTwo ? 1'b0 : m1), .measInputTwo(useTwo ? m1 : 1'b0),
    .acqBlockDone(blkDone), .acqStart(acqStart), .armed(armed));
  tds_trig_model partner (.mclk(mclk), .fire(fire), .sel(sel), .lvl(lvl), .falling(falling),
    .evt(evt), .extTrigCmp(cmp), .lineZero(lz), .lineOne(l1), .measOne(m1));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A hung handshake must still reach the verdict.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // Watcher: pops the oldest note as each result appears at the ports.
  always @(posedge mclk) begin : mon
    logic [20:0] note;
    if (bvalid === 1'b1 && bready) check(34'(bresp), 34'(qb.pop_front()), "write response");
    if (rvalid === 1'b1 && rready) check({rresp, rdata}, qr.pop_front(), "read data");
    if (acqStart === 1'b1) begin
      note = qa.pop_front();
      check(34'(note[20] ? ev : lat), 34'(note[19:0]), "start timing");
    end
    // Latency and events count from the first cycle after the trigger is taken.
    lat <= (armed === 1'b1) ? 0 : lat + 1;
    ev <= (armed === 1'b1) ? 0 : ev + int'(m1 && !mPrev);
    mPrev <= m1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    qb.push_back(r);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge mclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    // One idle edge, so a following call never re-raises bready in this step.
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    qr.push_back(e);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic strobe(input logic [2:0] s, input logic [2:0] l);
    sel <= s;
    lvl <= l;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  // Waits until every noted start has been seen, then ends the block.
  task automatic wait_acq();
    while (qa.size() != 0) @(posedge mclk);
    blkDone <= 1'b1;
    @(posedge mclk);
    blkDone <= 1'b0;
  endtask
  initial begin : main
    int st, k, fl;
    void'($urandom(46));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(tds_pkg::ADDR_TRIG_CFG, 34'h0);
    rd(tds_pkg::ADDR_DELAY_TIME, {14'h0, tds_pkg::DELAY_DEFAULT_STEPS});
    rd(tds_pkg::ADDR_EVENT_COUNT, {14'h0, tds_pkg::EVENT_COUNT_DEFAULT});
    rd(8'h1c, {tds_pkg::RESP_SLVERR, 32'h0});
    wr(tds_pkg::ADDR_STATUS, 32'h1, tds_pkg::RESP_SLVERR);
    wr(tds_pkg::ADDR_DELAY_TIME, 32'h0, tds_pkg::RESP_OKAY);
    rd(tds_pkg::ADDR_DELAY_TIME, {14'h0, tds_pkg::DELAY_MIN_STEPS});
    wr(tds_pkg::ADDR_DELAY_TIME, 32'hfffff, tds_pkg::RESP_OKAY);
    rd(tds_pkg::ADDR_DELAY_TIME, {14'h0, tds_pkg::DELAY_MAX_STEPS});
    wr(tds_pkg::ADDR_EVENT_COUNT, 32'hfffff, tds_pkg::RESP_OKAY);
    rd(tds_pkg::ADDR_EVENT_COUNT, 34'hfffff);
    // Only byte lane zero is written; the upper bytes must keep their old value.
    strb <= 4'h1;
    wr(tds_pkg::ADDR_EVENT_COUNT, 32'h123ab, tds_pkg::RESP_OKAY);
    strb <= 4'hf;
    rd(tds_pkg::ADDR_EVENT_COUNT, 34'hfffab);
    $display("test registers done");
    qa.push_back(21'h0);
    wr(tds_pkg::ADDR_CTRL, 32'h1, tds_pkg::RESP_OKAY);
    wait_acq();
    $display("test immediate done");
    // Every non-immediate source, random threshold and edge; odd sources use the timer.
    for (int s = 1; s < 6; s++) begin
      k = $urandom % 5;
      fl = $urandom % 2;
      st = 3 + $urandom % 58;
      wr(tds_pkg::ADDR_TRIG_CFG, {25'h0, 3'(k), 1'(fl), 3'(s)}, tds_pkg::RESP_OKAY);
      falling <= 1'(fl);
      wr(tds_pkg::ADDR_DELAY_SRC, {30'h0, s[0] ? tds_pkg::DSRC_TIMER : tds_pkg::DSRC_IMMEDIATE},
        tds_pkg::RESP_OKAY);
      wr(tds_pkg::ADDR_DELAY_TIME, 32'(st), tds_pkg::RESP_OKAY);
      qa.push_back(s[0] ? 21'((st * 25 + 39) / 40 + 1) : 21'h0);
      wr(tds_pkg::ADDR_CTRL, 32'h1, tds_pkg::RESP_OKAY);
      while (armed !== 1'b1) @(posedge mclk);
      if (s == 1) begin
        strobe(3'h0, 3'((k + 1) % 5));
        repeat (8) @(posedge mclk);
        check(34'(armed), 34'h1, "trigger on unselected threshold");
      end
      strobe(s == 1 ? 3'h0 : (s < 4 ? 3'h1 : 3'h2), 3'(k));
      wait_acq();
    end
    $display("test sources done");
    wr(tds_pkg::ADDR_TRIG_CFG, 32'h0, tds_pkg::RESP_OKAY);
    falling <= 1'b0;
    wr(tds_pkg::ADDR_DELAY_SRC, {30'h0, tds_pkg::DSRC_INPUT}, tds_pkg::RESP_OKAY);
    // Counts 0, 1 and 3; each run must reload its own count.
    for (int n = 0; n < 4; n += n + 1) begin
      // The last count runs single-channel on input two, so the other input stays quiet.
      if (n == 3) begin
        wr(tds_pkg::ADDR_TRIG_CFG, 32'h100, tds_pkg::RESP_OKAY);
        useTwo <= 1'b1;
      end
      wr(tds_pkg::ADDR_EVENT_COUNT, 32'(n), tds_pkg::RESP_OKAY);
      qa.push_back({1'b1, 20'(n)});
      wr(tds_pkg::ADDR_CTRL, 32'h1, tds_pkg::RESP_OKAY);
      repeat (4) @(posedge mclk);
      repeat (n + 1) begin
        evt <= 1'b1;
        @(posedge mclk);
        evt <= 1'b0;
        repeat (7) @(posedge mclk);
      end
      wait_acq();
    end
    $display("test event delay done");
    wr(tds_pkg::ADDR_DELAY_SRC, 32'h0, tds_pkg::RESP_OKAY);
    wr(tds_pkg::ADDR_TRIG_CFG, {29'h0, tds_pkg::SRC_LINE_ZERO}, tds_pkg::RESP_OKAY);
    wr(tds_pkg::ADDR_BLOCK_COUNT, 32'h2, tds_pkg::RESP_OKAY);
    wr(tds_pkg::ADDR_CTRL, 32'h1, tds_pkg::RESP_OKAY);
    for (int b = 0; b < 2; b++) begin
      k = 0;
      while (armed !== 1'b1 && k < 50) begin
        @(posedge mclk);
        k++;
      end
      if (b == 1) check(34'(k <= tds_pkg::REARM_MAX_CYCLES), 34'h1, "re-arm gap");
      qa.push_back(21'h0);
      strobe(3'h1, 3'h0);
      wait_acq();
    end
    $display("test blocks done");
    check(34'(qb.size() + qr.size() + qa.size()), 34'h0, "results outstanding");
    test_done();
  end
endmodule // trigger_delay_sequencer_tb
`default_nettype wire
